// ### verilog/port_def_mode_pin_mux.sv
// Function
// - High-byte pins are data bus in expanded modes, general I/O in modes 3, 7.
// - Low-byte pins are data bus only for expanded 16-bit bus, else general I/O.
// - Expanded: clock pin drives system clock when direction bit 1, reset 1.
// - Single-chip: clock pin direction bit resets to 0, pin starts as input.
// - Expanded: four pins output address, read, upper and lower write strobes.
// - Single-chip: four interrupt pins are general I/O and feed requests 3 to 0.
// - Interrupt request inputs pass through hysteresis input buffers.
// - Expanded, stall and request-out enables both 0: shared pin I/O plus request 2.
// - Expanded, stall enable 1, request-out 0: shared pin is wait input, feeds request 2.
// - Expanded, stall 0, request-out 1: shared pin drives bus request output.
// - Expanded, release enable 0: two pins are I/O feeding requests 1 and 0.
// - Expanded, release enable 1: bus request input and bus acknowledge output.
`timescale 1ns/1ps
module port_def_mode_pin_mux #(
    parameter int IRQ_LEN = pinmux_pkg::IRQ_FILTER_LEN
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] mode_strap,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [15:0] bus_dout,
    input wire logic bus_dout_en,
    output logic [15:0] bus_din,
    input wire logic address_strobe_n,
    input wire logic read_strobe_n,
    input wire logic upper_write_strobe_n,
    input wire logic lower_write_strobe_n,
    output logic bus_stall_n,
    input wire logic bus_request_output_n,
    output logic bus_request_input_n,
    input wire logic bus_ack_n,
    output logic [3:0] irq_req_n,
    input wire logic [7:0] hi_pad_rx,
    output logic [7:0] hi_pad_tx,
    output logic [7:0] hi_pad_oe_n,
    input wire logic [7:0] lo_pad_rx,
    output logic [7:0] lo_pad_tx,
    output logic [7:0] lo_pad_oe_n,
    input wire logic [7:0] ctl_pad_rx,
    output logic [7:0] ctl_pad_tx,
    output logic [7:0] ctl_pad_oe_n
);
    logic rst_meta_q;
    logic rst_sync_n_q;
    logic rst_n;
    logic init_q;
    logic [2:0] mode_q;
    logic single_chip;
    logic expanded;
    pinmux_pkg::slave_state_t state_q;
    logic [31:0] readdata_q;
    logic [31:0] rd_word;
    logic wr_ok;
    logic wide_bus_q;
    logic bus_stall_enable_q;
    logic bus_request_out_enable_q;
    logic bus_release_enable_q;
    logic [7:0] hi_dir_q;
    logic [7:0] hi_data_q;
    logic [7:0] lo_dir_q;
    logic [7:0] lo_data_q;
    logic [7:0] ctl_dir_q;
    logic [7:0] ctl_data_q;
    logic [7:0] ctl_alt_en;
    logic [7:0] ctl_alt_dir;
    logic [7:0] ctl_alt_val;
    logic [15:0] bus_din_q;
    logic bus_stall_n_q;
    logic bus_request_input_n_q;
    logic [3:0] irq_clean;

    // Two-stage reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_n_q;

    // Mode strap is caught on the first edge after release; until then the
    // reset mode is single-chip so every pin stays an input.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= 1'b0;
            mode_q <= pinmux_pkg::MODE_RESET;
        end else if (!init_q) begin
            init_q <= 1'b1;
            mode_q <= mode_strap;
        end
    end

    assign single_chip = (mode_q == pinmux_pkg::MODE_SINGLE_A) ||
                         (mode_q == pinmux_pkg::MODE_SINGLE_B);
    assign expanded = init_q && !single_chip;

    // Avalon slave: one wait cycle, then the answer cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pinmux_pkg::SL_IDLE;
        end else begin
            case (state_q)
                pinmux_pkg::SL_IDLE: begin
                    if ((read || write) && init_q) begin
                        state_q <= pinmux_pkg::SL_ANSWER;
                    end
                end
                pinmux_pkg::SL_ANSWER: begin
                    state_q <= pinmux_pkg::SL_IDLE;
                end
                default: begin
                    state_q <= pinmux_pkg::SL_IDLE;
                end
            endcase
        end
    end

    assign waitrequest = (state_q != pinmux_pkg::SL_ANSWER);
    assign wr_ok = write && (state_q == pinmux_pkg::SL_ANSWER);

    always_comb begin
        case (address)
            pinmux_pkg::OFS_CTRL: begin
                rd_word = 32'({bus_release_enable_q, bus_request_out_enable_q,
                               bus_stall_enable_q, wide_bus_q});
            end
            pinmux_pkg::OFS_STATUS: begin
                rd_word = 32'({expanded, single_chip, mode_q});
            end
            pinmux_pkg::OFS_HI_DIR: rd_word = 32'(hi_dir_q);
            pinmux_pkg::OFS_HI_DATA: rd_word = 32'(hi_data_q);
            pinmux_pkg::OFS_LO_DIR: rd_word = 32'(lo_dir_q);
            pinmux_pkg::OFS_LO_DATA: rd_word = 32'(lo_data_q);
            pinmux_pkg::OFS_CTL_DIR: rd_word = 32'(ctl_dir_q);
            pinmux_pkg::OFS_CTL_DATA: rd_word = 32'(ctl_data_q);
            pinmux_pkg::OFS_HI_PINS: rd_word = 32'(hi_pad_rx);
            pinmux_pkg::OFS_LO_PINS: rd_word = 32'(lo_pad_rx);
            pinmux_pkg::OFS_CTL_PINS: rd_word = 32'(ctl_pad_rx);
            default: rd_word = 32'(1'b0);
        endcase
    end

    // Read data is latched in the wait cycle so it stands through the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_q <= 32'(1'b0);
        end else if (state_q == pinmux_pkg::SL_IDLE && read && init_q) begin
            readdata_q <= rd_word;
        end
    end
    assign readdata = readdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {bus_release_enable_q, bus_request_out_enable_q,
             bus_stall_enable_q, wide_bus_q} <= pinmux_pkg::CTRL_RESET;
        end else if (wr_ok && address == pinmux_pkg::OFS_CTRL) begin
            wide_bus_q <= writedata[pinmux_pkg::CTRL_WIDE];
            bus_stall_enable_q <= writedata[pinmux_pkg::CTRL_STALL];
            bus_request_out_enable_q <= writedata[pinmux_pkg::CTRL_REQOUT];
            bus_release_enable_q <= writedata[pinmux_pkg::CTRL_RELEASE];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_dir_q <= pinmux_pkg::DIR_RESET;
            lo_dir_q <= pinmux_pkg::DIR_RESET;
        end else if (wr_ok) begin
            if (address == pinmux_pkg::OFS_HI_DIR) begin
                hi_dir_q <= writedata[7:0];
            end
            if (address == pinmux_pkg::OFS_LO_DIR) begin
                lo_dir_q <= writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_data_q <= pinmux_pkg::DATA_RESET;
            lo_data_q <= pinmux_pkg::DATA_RESET;
            ctl_data_q <= pinmux_pkg::DATA_RESET;
        end else if (wr_ok) begin
            if (address == pinmux_pkg::OFS_HI_DATA) begin
                hi_data_q <= writedata[7:0];
            end
            if (address == pinmux_pkg::OFS_LO_DATA) begin
                lo_data_q <= writedata[7:0];
            end
            if (address == pinmux_pkg::OFS_CTL_DATA) begin
                ctl_data_q <= writedata[7:0];
            end
        end
    end

    // Clock pin direction takes its mode-dependent reset value at strap time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_dir_q <= pinmux_pkg::DIR_RESET;
        end else if (!init_q) begin
            ctl_dir_q[pinmux_pkg::CLK_PIN] <=
                (mode_strap != pinmux_pkg::MODE_SINGLE_A) &&
                (mode_strap != pinmux_pkg::MODE_SINGLE_B);
        end else if (wr_ok && address == pinmux_pkg::OFS_CTL_DIR) begin
            ctl_dir_q <= writedata[7:0];
        end
    end

    pad_mux_if #(.W(8)) hi_if ();
    pad_mux_if #(.W(8)) lo_if ();
    pad_mux_if #(.W(8)) ctl_if ();

    assign hi_if.dir = hi_dir_q;
    assign hi_if.data = hi_data_q;
    assign hi_if.alt_en = {8{expanded}};
    assign hi_if.alt_dir = {8{bus_dout_en}};
    assign hi_if.alt_val = bus_dout[15:8];

    assign lo_if.dir = lo_dir_q;
    assign lo_if.data = lo_data_q;
    assign lo_if.alt_en = {8{expanded && wide_bus_q}};
    assign lo_if.alt_dir = {8{bus_dout_en}};
    assign lo_if.alt_val = bus_dout[7:0];

    // When both stall and request-out are enabled the wait input wins, so
    // the pin is never driven against an external wait source.
    always_comb begin
        ctl_alt_en = 8'h00;
        ctl_alt_dir = 8'h00;
        ctl_alt_val = 8'hFF;
        if (expanded) begin
            ctl_alt_en[6:3] = 4'hF;
            ctl_alt_dir[6:3] = 4'hF;
            ctl_alt_val[6:3] = {address_strobe_n, read_strobe_n,
                                upper_write_strobe_n, lower_write_strobe_n};
            if (bus_stall_enable_q) begin
                ctl_alt_en[2] = 1'b1;
            end else if (bus_request_out_enable_q) begin
                ctl_alt_en[2] = 1'b1;
                ctl_alt_dir[2] = 1'b1;
                ctl_alt_val[2] = bus_request_output_n;
            end
            if (bus_release_enable_q) begin
                ctl_alt_en[1:0] = 2'h3;
                ctl_alt_dir[1] = 1'b1;
                ctl_alt_val[1] = bus_ack_n;
            end
        end
    end

    assign ctl_if.dir = ctl_dir_q;
    assign ctl_if.data = ctl_data_q;
    assign ctl_if.alt_en = ctl_alt_en;
    assign ctl_if.alt_dir = ctl_alt_dir;
    assign ctl_if.alt_val = ctl_alt_val;

    pad_mux #(.W(8)) u_hi (.clk(clk), .rst_n(rst_n), .pm(hi_if));
    pad_mux #(.W(8)) u_lo (.clk(clk), .rst_n(rst_n), .pm(lo_if));
    pad_mux #(.W(8)) u_ctl (.clk(clk), .rst_n(rst_n), .pm(ctl_if));

    assign hi_pad_tx = hi_if.tx;
    assign hi_pad_oe_n = hi_if.oe_n;
    assign lo_pad_tx = lo_if.tx;
    assign lo_pad_oe_n = lo_if.oe_n;
    // The clock pin carries clk itself; its enable follows the direction bit
    assign ctl_pad_tx = {clk, ctl_if.tx[6:0]};
    assign ctl_pad_oe_n = ctl_if.oe_n;

    // Wait and bus request inputs to the bus controller are idle-high unless enabled; bus_din always follows the pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_din_q <= 16'h0000;
            bus_stall_n_q <= 1'b1;
            bus_request_input_n_q <= 1'b1;
        end else begin
            bus_din_q <= {hi_pad_rx, lo_pad_rx};
            bus_stall_n_q <= (expanded && bus_stall_enable_q) ? ctl_pad_rx[2] : 1'b1;
            bus_request_input_n_q <= (expanded && bus_release_enable_q) ?
                                     ctl_pad_rx[0] : 1'b1;
        end
    end
    assign bus_din = bus_din_q;
    assign bus_stall_n = bus_stall_n_q;
    assign bus_request_input_n = bus_request_input_n_q;

    irq_filter #(.W(4), .LEN(IRQ_LEN)) u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .raw(ctl_pad_rx[3:0]),
        .clean(irq_clean)
    );

    // Pin 3 is the lower write strobe in expanded modes, so request 3 idles
    assign irq_req_n = {expanded ? 1'b1 : irq_clean[3], irq_clean[2:0]};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_hi_bus;
        expanded && bus_dout_en |=> hi_pad_oe_n == 8'h00 && hi_pad_tx == $past(bus_dout[15:8]);
    endproperty
    a_hi_bus: assert property (p_hi_bus) else $error("high byte not on data bus");

    property p_hi_port;
        init_q && single_chip |=> hi_pad_oe_n == ~$past(hi_dir_q) && hi_pad_tx == $past(hi_data_q);
    endproperty
    a_hi_port: assert property (p_hi_port) else $error("high byte not port");

    property p_lo_narrow;
        expanded && !wide_bus_q |=> lo_pad_oe_n == ~$past(lo_dir_q);
    endproperty
    a_lo_narrow: assert property (p_lo_narrow) else $error("low byte not port");

    property p_lo_wide;
        expanded && wide_bus_q && !bus_dout_en |=> lo_pad_oe_n == 8'hFF;
    endproperty
    a_lo_wide: assert property (p_lo_wide) else $error("low byte not bus input");

    property p_clk_expanded;
        $rose(init_q) && expanded |-> ctl_dir_q[7] ##1 !ctl_pad_oe_n[7];
    endproperty
    a_clk_expanded: assert property (p_clk_expanded) else $error("clock pin not out");

    property p_clk_single;
        $rose(init_q) && single_chip |-> !ctl_dir_q[7] ##1 ctl_pad_oe_n[7];
    endproperty
    a_clk_single: assert property (p_clk_single) else $error("clock pin not input");

    property p_strobes;
        expanded |=> ctl_pad_oe_n[6:3] == 4'h0 && ctl_pad_tx[6:3] ==
            $past({address_strobe_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n});
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobes not driven");

    property p_irq_single;
        single_chip && init_q && ctl_pad_rx[3] == 1'b0 [*5] |-> irq_req_n[3] == 1'b0;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("request 3 lost");

    property p_irq_filter;
        $changed(ctl_pad_rx[2]) |=> $stable(irq_req_n[2]);
    endproperty
    a_irq_filter: assert property (p_irq_filter) else $error("glitch passed");

    property p_shared_io;
        expanded && !bus_stall_enable_q && !bus_request_out_enable_q |=>
            ctl_pad_oe_n[2] == ~$past(ctl_dir_q[2]) && bus_stall_n;
    endproperty
    a_shared_io: assert property (p_shared_io) else $error("shared pin not port");

    property p_stall;
        expanded && bus_stall_enable_q |=> ctl_pad_oe_n[2] && bus_stall_n == $past(ctl_pad_rx[2]);
    endproperty
    a_stall: assert property (p_stall) else $error("wait input wrong");

    property p_reqout;
        expanded && !bus_stall_enable_q && bus_request_out_enable_q |=>
            !ctl_pad_oe_n[2] && ctl_pad_tx[2] == $past(bus_request_output_n);
    endproperty
    a_reqout: assert property (p_reqout) else $error("request output wrong");

    property p_release_off;
        expanded && !bus_release_enable_q |=> bus_request_input_n &&
            ctl_pad_oe_n[1:0] == ~$past(ctl_dir_q[1:0]);
    endproperty
    a_release_off: assert property (p_release_off) else $error("pins not port");

    property p_release_on;
        expanded && bus_release_enable_q |=> !ctl_pad_oe_n[1] && ctl_pad_oe_n[0] &&
            ctl_pad_tx[1] == $past(bus_ack_n);
    endproperty
    a_release_on: assert property (p_release_on) else $error("release pins wrong");

    property p_revert;
        !expanded |=> ctl_pad_oe_n[6:0] == ~$past(ctl_dir_q[6:0]);
    endproperty
    a_revert: assert property (p_revert) else $error("pins not under port");

    property p_answer;
        init_q && (read || write) |-> ##[0:2] !waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
endmodule

// ### verilog/pinmux_pkg.sv
package pinmux_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_HI_DIR = 6'h08;
    localparam logic [5:0] OFS_HI_DATA = 6'h0C;
    localparam logic [5:0] OFS_LO_DIR = 6'h10;
    localparam logic [5:0] OFS_LO_DATA = 6'h14;
    localparam logic [5:0] OFS_CTL_DIR = 6'h18;
    localparam logic [5:0] OFS_CTL_DATA = 6'h1C;
    localparam logic [5:0] OFS_HI_PINS = 6'h20;
    localparam logic [5:0] OFS_LO_PINS = 6'h24;
    localparam logic [5:0] OFS_CTL_PINS = 6'h28;
    // Control register field positions
    localparam int CTRL_WIDE = 0;
    localparam int CTRL_STALL = 1;
    localparam int CTRL_REQOUT = 2;
    localparam int CTRL_RELEASE = 3;
    // Operating modes
    localparam logic [2:0] MODE_SINGLE_A = 3'h3;
    localparam logic [2:0] MODE_SINGLE_B = 3'h7;
    localparam logic [2:0] MODE_RESET = 3'h7;
    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Bit of the control port that carries the clock output
    localparam int CLK_PIN = 7;
    // Consecutive samples an interrupt pin must hold before it is believed
    localparam int IRQ_FILTER_LEN = 4;
    typedef enum logic {SL_IDLE, SL_ANSWER} slave_state_t;
endpackage

// ### verilog/pad_mux_if.sv
`timescale 1ns/1ps
interface pad_mux_if #(parameter int W = 8);
    logic [W-1:0] dir;
    logic [W-1:0] data;
    logic [W-1:0] alt_en;
    logic [W-1:0] alt_dir;
    logic [W-1:0] alt_val;
    logic [W-1:0] tx;
    logic [W-1:0] oe_n;
    modport ctrl (output dir, data, alt_en, alt_dir, alt_val, input tx, oe_n);
    modport mux (input dir, data, alt_en, alt_dir, alt_val, output tx, oe_n);
endinterface

// ### verilog/pad_mux.sv
`timescale 1ns/1ps
module pad_mux #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    pad_mux_if.mux pm
);
    // Alternate function owns a pin only while its enable is up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm.tx <= '0;
            pm.oe_n <= '1;
        end else begin
            pm.tx <= (pm.alt_en & pm.alt_val) | (~pm.alt_en & pm.data);
            pm.oe_n <= ~((pm.alt_en & pm.alt_dir) | (~pm.alt_en & pm.dir));
        end
    end
endmodule

// ### verilog/irq_filter.sv
`timescale 1ns/1ps
module irq_filter #(
    parameter int W = 4,
    parameter int LEN = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] clean
);
    localparam int CW = $clog2(LEN) + 1;
    // Digital stand-in for input hysteresis: a level must hold LEN samples
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= '0;
                clean[i] <= 1'b1;
            end else if (raw[i] == clean[i]) begin
                cnt_q <= '0;
            end else if (cnt_q == CW'(LEN - 1)) begin
                cnt_q <= '0;
                clean[i] <= raw[i];
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end
endmodule

// ### dv/ext_bus_model.sv
`timescale 1ns/1ps
module ext_bus_model (
    input wire logic clk,
    input wire logic [7:0] hi_tx,
    input wire logic [7:0] hi_oe_n,
    input wire logic [7:0] lo_tx,
    input wire logic [7:0] lo_oe_n,
    input wire logic [7:0] ctl_tx,
    input wire logic [7:0] ctl_oe_n,
    input wire logic [7:0] ext_hi,
    input wire logic [7:0] ext_hi_en,
    input wire logic [7:0] ext_ctl,
    input wire logic [7:0] ext_ctl_en,
    output logic [7:0] hi_rx,
    output logic [7:0] lo_rx,
    output logic [7:0] ctl_rx
);
    // Control lines have no pull-up, so a released one wanders every cycle
    logic [7:0] drift_q = 8'h55;
    always_ff @(posedge clk) begin
        drift_q <= ~drift_q;
    end
    // Data lines carry pull-ups and read high once released
    assign hi_rx = (~hi_oe_n & hi_tx) | (hi_oe_n & ((ext_hi_en & ext_hi) | ~ext_hi_en));
    assign lo_rx = (~lo_oe_n & lo_tx) | lo_oe_n;
    assign ctl_rx = (~ctl_oe_n & ctl_tx)
        | (ctl_oe_n & ((ext_ctl_en & ext_ctl) | (~ext_ctl_en & drift_q)));
endmodule

// ### dv/port_def_mode_pin_mux_tb_top.sv
`timescale 1ns/1ps
module port_def_mode_pin_mux_tb_top;
    localparam int IRQ_LEN = 3;
    logic clk, nrst, read, write, waitrequest, bus_dout_en;
    logic bus_stall_n, bus_request_output_n, bus_request_input_n, bus_ack_n;
    logic [2:0] mode_strap;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [15:0] bus_dout, bus_din;
    logic [3:0] strobe_n, irq_req_n;
    logic [7:0] hi_rx, hi_tx, hi_oe_n, lo_rx, lo_tx, lo_oe_n, ctl_rx, ctl_tx, ctl_oe_n;
    logic [7:0] ext_hi, ext_hi_en, ext_ctl, ext_ctl_en;
    int err_total, num_checks;

    port_def_mode_pin_mux #(.IRQ_LEN(IRQ_LEN)) i_port_def_mode_pin_mux (
        .clk(clk), .nrst(nrst), .mode_strap(mode_strap), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .bus_dout(bus_dout), .bus_dout_en(bus_dout_en),
        .bus_din(bus_din), .address_strobe_n(strobe_n[3]), .read_strobe_n(strobe_n[2]),
        .upper_write_strobe_n(strobe_n[1]), .lower_write_strobe_n(strobe_n[0]),
        .bus_stall_n(bus_stall_n), .bus_request_output_n(bus_request_output_n),
        .bus_request_input_n(bus_request_input_n), .bus_ack_n(bus_ack_n),
        .irq_req_n(irq_req_n), .hi_pad_rx(hi_rx), .hi_pad_tx(hi_tx), .hi_pad_oe_n(hi_oe_n),
        .lo_pad_rx(lo_rx), .lo_pad_tx(lo_tx), .lo_pad_oe_n(lo_oe_n),
        .ctl_pad_rx(ctl_rx), .ctl_pad_tx(ctl_tx), .ctl_pad_oe_n(ctl_oe_n));

    ext_bus_model i_ext_bus_model (
        .clk(clk), .hi_tx(hi_tx), .hi_oe_n(hi_oe_n), .lo_tx(lo_tx), .lo_oe_n(lo_oe_n),
        .ctl_tx(ctl_tx), .ctl_oe_n(ctl_oe_n), .ext_hi(ext_hi), .ext_hi_en(ext_hi_en),
        .ext_ctl(ext_ctl), .ext_ctl_en(ext_ctl_en), .hi_rx(hi_rx), .lo_rx(lo_rx),
        .ctl_rx(ctl_rx));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge, before the
    // slave's registers move in that time step
    task automatic bus_xfer(input logic [5:0] a, input logic wr, input logic [7:0] wd);
        int n;
        logic w;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= {24'h00_0000, wd};
        w = 1'b1;
        n = 0;
        while (w !== 1'b0 && n < 50) begin
            @(posedge clk);
            w = waitrequest;
            rd = readdata;
            n++;
        end
        read <= 1'b0;
        write <= 1'b0;
        if (w !== 1'b0) begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus_xfer(a, 1'b1, d);
    endtask

    task automatic rdr(input logic [5:0] a);
        bus_xfer(a, 1'b0, 8'h00);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        nrst <= 1'b0;
        mode_strap <= m;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        wt(5);
    endtask

    task automatic t_single;
        do_reset(3'h3);
        chk(ctl_oe_n, 8'hFF);
        rdr(pinmux_pkg::OFS_STATUS);
        chk(rd, 32'h0000_000B);
        wr(pinmux_pkg::OFS_HI_DIR, 8'hFF);
        wr(pinmux_pkg::OFS_HI_DATA, 8'hA5);
        wt(3);
        chk({hi_oe_n, hi_tx}, 32'h0000_00A5);
        @(posedge clk);
        strobe_n <= 4'h0;
        wr(pinmux_pkg::OFS_CTL_DIR, 8'h78);
        wr(pinmux_pkg::OFS_CTL_DATA, 8'h50);
        wt(3);
        chk({ctl_oe_n[6:3], ctl_tx[6:3]}, 32'h0000_000A);
        wr(pinmux_pkg::OFS_CTL_DIR, 8'h80);
        wt(3);
        chk({ctl_oe_n[7], ctl_tx[7]}, 32'h0000_0000);
        @(posedge clk);
        ext_ctl_en <= 8'h0F;
        ext_ctl <= 8'h0F;
        wt(IRQ_LEN + 3);
        @(posedge clk);
        ext_ctl <= 8'h00;
        repeat (IRQ_LEN - 1) @(posedge clk);
        ext_ctl <= 8'h0F;
        wt(IRQ_LEN + 3);
        chk(irq_req_n, 32'h0000_000F);
        @(posedge clk);
        ext_ctl <= 8'h00;
        wt(IRQ_LEN + 3);
        chk(irq_req_n, 32'h0000_0000);
        wr(6'h3C, 8'hFF);
        rdr(6'h3C);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic t_expanded;
        @(posedge clk);
        strobe_n <= 4'h4;
        bus_dout <= 16'h3C96;
        bus_dout_en <= 1'b1;
        ext_ctl_en <= 8'h07;
        ext_ctl <= 8'h03;
        do_reset(3'h4);
        chk(ctl_oe_n[7], 32'h0000_0000);
        chk({ctl_oe_n[6:3], ctl_tx[6:3]}, 32'h0000_0004);
        chk({hi_oe_n, hi_tx}, 32'h0000_003C);
        chk(lo_oe_n, 32'h0000_00FF);
        rdr(pinmux_pkg::OFS_STATUS);
        chk(rd, 32'h0000_0014);
        wr(pinmux_pkg::OFS_LO_DIR, 8'hFF);
        wr(pinmux_pkg::OFS_LO_DATA, 8'h5A);
        wt(3);
        chk({lo_oe_n, lo_tx}, 32'h0000_005A);
        wr(pinmux_pkg::OFS_CTRL, 8'h01);
        wt(IRQ_LEN + 3);
        chk({lo_oe_n, lo_tx}, 32'h0000_0096);
        chk({bus_stall_n, ctl_oe_n[2], irq_req_n}, 32'h0000_003B);
        @(posedge clk);
        bus_dout_en <= 1'b0;
        ext_hi_en <= 8'hFF;
        ext_hi <= 8'hC3;
        wt(3);
        chk({hi_oe_n, lo_oe_n, bus_din}, 32'hFFFF_C3FF);
        wr(pinmux_pkg::OFS_CTRL, 8'h03);
        wt(3);
        chk({bus_stall_n, ctl_oe_n[2]}, 32'h0000_0001);
        @(posedge clk);
        bus_request_output_n <= 1'b1;
        wr(pinmux_pkg::OFS_CTRL, 8'h05);
        wt(IRQ_LEN + 3);
        chk({bus_stall_n, ctl_oe_n[2], ctl_tx[2], irq_req_n[2]}, 32'h0000_000B);
        chk({bus_request_input_n, ctl_oe_n[1:0]}, 32'h0000_0007);
        @(posedge clk);
        ext_ctl <= 8'h02;
        bus_ack_n <= 1'b0;
        wr(pinmux_pkg::OFS_CTRL, 8'h09);
        wt(IRQ_LEN + 3);
        chk({bus_request_input_n, ctl_oe_n[1], ctl_tx[1]}, 32'h0000_0000);
        chk(irq_req_n[1:0], 32'h0000_0000);
        rdr(pinmux_pkg::OFS_CTRL);
        chk(rd, 32'h0000_0009);
        wr(pinmux_pkg::OFS_CTRL, 8'h01);
        wt(3);
        chk({bus_request_input_n, ctl_oe_n[1]}, 32'h0000_0003);
    endtask

    // Second single-chip mode: bus data offered, yet the control and high-byte pins stay inputs
    task automatic t_single_b;
        @(posedge clk);
        bus_dout_en <= 1'b1;
        do_reset(3'h7);
        chk({ctl_oe_n, hi_oe_n}, 32'h0000_FFFF);
        rdr(pinmux_pkg::OFS_STATUS);
        chk(rd, 32'h0000_000F);
    endtask

    initial begin
        nrst = 1'b0;
        mode_strap = 3'h3;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        bus_dout = 16'h0000;
        bus_dout_en = 1'b0;
        strobe_n = 4'hF;
        bus_request_output_n = 1'b1;
        bus_ack_n = 1'b1;
        ext_hi = 8'h00;
        ext_hi_en = 8'h00;
        ext_ctl = 8'h00;
        ext_ctl_en = 8'h00;
        err_total = 0;
        num_checks = 0;
        t_single();
        t_expanded();
        t_single_b();
        stop_test();
    end
endmodule
